/* verilog/lod_pkg.sv */
// Shared constants and types for the latched output driver target port
`default_nettype none
package lod_pkg;
    localparam logic [3:0] GROUP_ID      = 4'hc;   // Fixed group field of the address byte
    localparam logic [7:0] SUB_LOAD      = 8'h11;  // Load or read back the data shift register
    localparam logic [7:0] SUB_XFER      = 8'h22;  // Copy shift register to output storage
    localparam logic [7:0] SUB_LOAD_XFER = 8'h44;  // Load, then copy in the same transaction
    localparam logic [7:0] DATA_RST      = 8'h00;  // Data shift register after reset
    localparam logic [7:0] OUT_RST       = 8'h00;  // Output storage after reset, all off
    localparam logic [2:0] BIT_LAST      = 3'h7;   // Index of the last bit of a byte

    // Pin levels of the two-wire bus, as seen at the block boundary
    typedef struct packed {
        logic scl;
        logic sda;
    } lod_bus_t;
endpackage
`default_nettype wire

/* verilog/lod_target.sv */
// Two-wire target port feeding a shift register and an output storage register
`timescale 1ns/100ps
`default_nettype none
module lod_target (
    input  wire logic             clk,        // System clock, 125 MHz
    input  wire logic             rst_n,      // Asynchronous reset, active low
    input  wire logic             ce,         // Clock enable, freezes all state when low
    input  wire lod_pkg::lod_bus_t bus_i,     // SCL and SDA pin levels, asynchronous
    input  wire logic [2:0]       addr_pins,  // Device select straps, asynchronous
    output logic                  sda_o,      // SDA drive value, always low
    output logic                  sda_oe,     // SDA pull-down enable, high while pulling
    output logic [7:0]            out_on,     // Output storage, one bit per output
    output logic [7:0]            shift_q     // Data shift register contents
);

    ////////////////////////////////////////////////////////////////////////////////
    // States of the transaction, one-hot
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_ADDR = 10'h002,
        ST_AACK = 10'h004,
        ST_SUB  = 10'h008,
        ST_SACK = 10'h010,
        ST_RXD  = 10'h020,
        ST_DACK = 10'h040,
        ST_TXD  = 10'h080,
        ST_TACK = 10'h100,
        ST_DONE = 10'h200
    } lod_state_t;

    // Subaddresses that the port answers
    function automatic logic sub_valid(input logic [7:0] s);
        sub_valid = (s == lod_pkg::SUB_LOAD) || (s == lod_pkg::SUB_XFER) ||
                    (s == lod_pkg::SUB_LOAD_XFER);
    endfunction

    lod_state_t  state_r;
    logic [2:0]  scl_sync_r;
    logic [2:0]  sda_sync_r;
    logic [2:0]  a_s1_r;
    logic [2:0]  a_s2_r;
    logic [7:0]  rx_r;
    logic [7:0]  tx_r;
    logic [7:0]  sub_r;
    logic [2:0]  cnt_r;
    logic        done_r;
    logic        rw_r;
    logic        sda_oe_r;
    logic        sda_o_r;
    logic [7:0]  data_r;
    logic [7:0]  out_r;
    logic        scl_s;
    logic        sda_s;
    logic        rise_ev;
    logic        fall_ev;
    logic        start_ev;
    logic        stop_ev;
    logic        byte_st;
    logic        addr_ok;
    logic        ld_data;
    logic        xfer_sub;
    logic        xfer_dat;

    ////////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers plus one history stage for edge finding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_r <= 3'h7;  // Idle bus reads high
            sda_sync_r <= 3'h7;
            a_s1_r     <= 3'h0;
            a_s2_r     <= 3'h0;
        end else if (ce) begin
            scl_sync_r <= {scl_sync_r[1:0], bus_i.scl};  // Clock only sampled
            sda_sync_r <= {sda_sync_r[1:0], bus_i.sda};
            a_s1_r     <= addr_pins;
            a_s2_r     <= a_s1_r;
        end
    end

    // Stage 0 is read only by stage 1; logic looks at stages 1 and 2
    assign scl_s    = scl_sync_r[1];
    assign sda_s    = sda_sync_r[1];
    assign rise_ev  = ce && scl_s && !scl_sync_r[2];
    assign fall_ev  = ce && !scl_s && scl_sync_r[2];
    // SDA edges with SCL high in both samples; legal data moves only with SCL low
    assign start_ev = ce && scl_s && scl_sync_r[2] && !sda_s && sda_sync_r[2];
    assign stop_ev  = ce && scl_s && scl_sync_r[2] && sda_s && !sda_sync_r[2];

    // Address byte check against group field and strap pins
    assign addr_ok  = (rx_r[7:4] == lod_pkg::GROUP_ID) && (rx_r[3:1] == a_s2_r);
    assign byte_st  = (state_r == ST_ADDR) || (state_r == ST_SUB) ||
                      (state_r == ST_RXD) || (state_r == ST_TXD);

    // Register strobes, all taken on the SCL fall that opens an acknowledge bit
    assign xfer_sub = fall_ev && done_r && (state_r == ST_SUB) && !rw_r &&
                      (rx_r == lod_pkg::SUB_XFER);
    assign ld_data  = fall_ev && done_r && (state_r == ST_RXD);
    assign xfer_dat = ld_data && (sub_r == lod_pkg::SUB_LOAD_XFER);

    ////////////////////////////////////////////////////////////////////////////////
    // Bit counter: eight rises close a byte, one rise closes an acknowledge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= 3'h0;
            done_r <= 1'b0;
            rx_r   <= 8'h00;
        end else if (start_ev || stop_ev) begin
            cnt_r  <= 3'h0;
            done_r <= 1'b0;
        end else if (fall_ev && done_r) begin
            cnt_r  <= 3'h0;
            done_r <= 1'b0;
        end else if (rise_ev) begin
            if (byte_st) begin
                rx_r   <= {rx_r[6:0], sda_s};  // MSB first
                cnt_r  <= cnt_r + 3'h1;
                done_r <= (cnt_r == lod_pkg::BIT_LAST);
            end else begin
                done_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transaction sequencer and open-drain SDA control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
            rw_r     <= 1'b0;
            sub_r    <= 8'h00;
            tx_r     <= 8'h00;
        end else if (stop_ev) begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else if (start_ev) begin
            state_r  <= ST_ADDR;  // Repeated start also restarts
            sda_oe_r <= 1'b0;
        end else if (fall_ev && done_r) begin
            case (state_r)
                ST_ADDR: begin
                    rw_r <= rx_r[0];
                    if (addr_ok) begin
                        state_r  <= ST_AACK;
                        sda_oe_r <= 1'b1;
                    end else begin
                        state_r  <= ST_DONE;  // Silent on mismatch
                    end
                end
                ST_AACK: begin
                    state_r  <= ST_SUB;
                    sda_oe_r <= 1'b0;
                end
                ST_SUB: begin
                    sub_r <= rx_r;
                    if (sub_valid(rx_r)) begin
                        state_r  <= ST_SACK;
                        sda_oe_r <= 1'b1;
                    end else begin
                        state_r  <= ST_DONE;  // No acknowledge
                    end
                end
                ST_SACK: begin
                    if (rw_r && (sub_r == lod_pkg::SUB_LOAD)) begin
                        state_r  <= ST_TXD;  // First bit out
                        sda_oe_r <= !data_r[7];
                        tx_r     <= {data_r[6:0], 1'b0};
                    end else if (!rw_r && (sub_r != lod_pkg::SUB_XFER)) begin
                        state_r  <= ST_RXD;
                        sda_oe_r <= 1'b0;
                    end else begin
                        state_r  <= ST_DONE;  // Data byte ignored
                        sda_oe_r <= 1'b0;
                    end
                end
                ST_RXD: begin
                    state_r  <= ST_DACK;
                    sda_oe_r <= 1'b1;
                end
                ST_DACK: begin
                    state_r  <= ST_DONE;  // Complete after data
                    sda_oe_r <= 1'b0;
                end
                ST_TXD: begin
                    state_r  <= ST_TACK;  // Release for the controller's answer
                    sda_oe_r <= 1'b0;
                end
                ST_TACK: begin
                    state_r  <= ST_DONE;
                end
                ST_IDLE, ST_DONE: begin
                    state_r  <= state_r;
                end
                default: begin
                    state_r  <= ST_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end else if (fall_ev && (state_r == ST_TXD)) begin
            sda_oe_r <= !tx_r[7];  // Low only by pulling
            tx_r     <= {tx_r[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data shift and output storage; only the strobes move them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_r  <= lod_pkg::DATA_RST;
            out_r   <= lod_pkg::OUT_RST;
            sda_o_r <= 1'b0;
        end else begin
            sda_o_r <= 1'b0;  // Never driven high
            if (ld_data) begin
                data_r <= rx_r;
            end
            if (xfer_dat) begin
                out_r <= rx_r;
            end else if (xfer_sub) begin
                out_r <= data_r;
            end
        end
    end

    assign sda_o   = sda_o_r;
    assign sda_oe  = sda_oe_r;
    assign out_on  = out_r;   // One turns the output on
    assign shift_q = data_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    oe_scl_low_a: assert property ($changed(sda_oe_r) |-> !scl_s)
        else $error("SDA drive changed while SCL high");
    drive_low_a: assert property (sda_o_r == 1'b0 && sda_o == 1'b0 && (!sda_oe_r ||
        state_r inside {ST_AACK, ST_SACK, ST_DACK, ST_TXD}))
        else $error("SDA driven high or pulled outside an answer");
    start_addr_a: assert property (start_ev && !stop_ev |=> state_r == ST_ADDR)
        else $error("Start not followed by address phase");
    stop_idle_a: assert property (stop_ev |=> state_r == ST_IDLE && !sda_oe_r)
        else $error("Stop did not end transaction");
    addr_nomatch_a: assert property (fall_ev && done_r && state_r == ST_ADDR
        && !start_ev && !stop_ev && !addr_ok |=> state_r == ST_DONE && !sda_oe_r)
        else $error("Acknowledged wrong address");
    sack_valid_a: assert property (state_r == ST_SACK |-> sub_valid(sub_r))
        else $error("Undefined subaddress acknowledged");
    out_change_a: assert property ($changed(out_r) |->
        $past(state_r) == ST_SUB || $past(state_r) == ST_RXD)
        else $error("Output storage changed outside transfer");
    data_change_a: assert property ($changed(data_r) |-> $past(state_r) == ST_RXD
        && state_r == ST_DACK)
        else $error("Shift register changed outside data load");
    xfer44_a: assert property (xfer_dat |=> out_r == data_r && out_r == $past(rx_r))
        else $error("Load and copy mismatch");
    xfer22_a: assert property (xfer_sub && !ld_data |=> out_r == $past(data_r))
        else $error("Copy command failed");
    read_first_a: assert property ($rose(state_r == ST_TXD) |->
        sda_oe_r == !data_r[7])
        else $error("Read data bit wrong");

    wr11_c: cover property (ld_data && sub_r == lod_pkg::SUB_LOAD);
    wr44_c: cover property (xfer_dat);
    xfer22_c: cover property (xfer_sub);
    read_c: cover property (state_r == ST_TACK);
    nack_c: cover property (fall_ev && done_r && state_r == ST_SUB && !sub_valid(rx_r));

endmodule
`default_nettype wire

/* verification/lod_ctl_model.sv */
// Behavioural two-wire bus controller that sources the clock and drives data
`timescale 1ns/100ps
`default_nettype none
module lod_ctl_model (
    input  wire logic clk,     // System clock
    input  wire logic sda_in,  // Resolved data line level
    output var logic  scl,     // Bus clock, sourced only here
    output var logic  sda_drv  // Zero pulls low, one releases to the pull-up
);
    // Idle bus released high, clock standing still
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Start: data falls while the clock is high
    task automatic bus_start();
        wait_clk(4);
        sda_drv <= 1'b0;
        wait_clk(4);
        scl <= 1'b0;
    endtask
    // Stop: data rises while the clock is high, then the bus rests
    task automatic bus_stop();
        wait_clk(3);
        sda_drv <= 1'b0;
        wait_clk(2);
        scl <= 1'b1;
        wait_clk(4);
        sda_drv <= 1'b1;
        wait_clk(6);
    endtask
    // One bit: 5 clk low, 3 clk high; data moves mid-low to keep clear of edges
    task automatic bit_slot(input logic b, output logic r);
        wait_clk(3);
        sda_drv <= b;
        wait_clk(2);
        scl <= 1'b1;
        wait_clk(3);
        r = sda_in;
        scl <= 1'b0;
    endtask
    // Eight bits MSB first plus the ninth; released bits let the target answer
    task automatic byte_slot(input logic [7:0] tx, input logic ak_tx,
                             output logic [7:0] rx, output logic ak);
        for (int i = 7; i >= 0; i--) bit_slot(tx[i], rx[i]);
        bit_slot(ak_tx, ak);
    endtask
endmodule
`default_nettype wire

/* verification/lod_target_tb.sv */
// Self-checking bench for the two-wire target port of the output driver
`timescale 1ns/100ps
`default_nettype none
module lod_target_tb;
    logic              clk, rst_n, ce, scl, sda_drv, sda_o, sda_oe;
    logic [2:0]        addr_pins;
    logic [7:0]        out_on, shift_q, exp_sh, exp_out;
    logic [31:0]       seed, rnd;
    logic [7:0]        dir_sub [6];
    wire logic         sda_wire;
    lod_pkg::lod_bus_t bus;
    int                num_errors, tests_run;

    // Pull-up shared by both open-drain parties
    assign sda_wire = sda_drv & ~sda_oe;
    assign bus = '{scl: scl, sda: sda_wire};

    lod_target lod_target_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_i(bus),
        .addr_pins(addr_pins), .sda_o(sda_o), .sda_oe(sda_oe), .out_on(out_on),
        .shift_q(shift_q));
    lod_ctl_model lod_ctl_model_inst (.clk(clk), .sda_in(sda_wire), .scl(scl),
        .sda_drv(sda_drv));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Expected ninth bits {address, subaddress, data}: zero where acknowledged
    function automatic logic [2:0] exp_ack(input logic hit, input logic rw, input logic [7:0] sub);
        logic known;
        known = sub inside {lod_pkg::SUB_LOAD, lod_pkg::SUB_XFER, lod_pkg::SUB_LOAD_XFER};
        return {~hit, ~(hit & known), ~(hit & ~rw & known & (sub != lod_pkg::SUB_XFER))};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Whole transaction: address, subaddress, one data byte, stop
    task automatic txn(input logic [3:0] grp, input logic [2:0] sel, input logic rw,
                       input logic [7:0] sub, input logic [7:0] dat);
        logic [7:0] rx, dummy;
        logic [2:0] ak, ea;
        logic       hit;
        hit = (grp == lod_pkg::GROUP_ID) && (sel == addr_pins);
        ea = exp_ack(hit, rw, sub);
        lod_ctl_model_inst.bus_start();
        lod_ctl_model_inst.byte_slot({grp, sel, rw}, 1'b1, dummy, ak[2]);
        lod_ctl_model_inst.byte_slot(sub, 1'b1, dummy, ak[1]);
        if (!ea[1] && !rw && sub == lod_pkg::SUB_XFER) exp_out = exp_sh;
        check(out_on, exp_out, "copy at subaddress ack");
        lod_ctl_model_inst.byte_slot(rw ? 8'hff : dat, 1'b1, rx, ak[0]);
        if (hit && rw && sub == lod_pkg::SUB_LOAD) check(rx, exp_sh, "read back");
        if (!ea[0]) exp_sh = dat;
        if (!ea[0] && sub == lod_pkg::SUB_LOAD_XFER) exp_out = dat;
        check({5'h00, ak}, {5'h00, ea}, "acknowledge pattern");
        lod_ctl_model_inst.bus_stop();
        check(shift_q, exp_sh, "shift register");
        check(out_on, exp_out, "output storage");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // The data line may only ever be pulled low
    always @(posedge clk) begin
        if (rst_n && sda_o !== 1'b0) begin
            num_errors++;
            $display("[ERR] %0t data line driven high", $time);
        end
    end
    // Whole run needs about 13000 clk; 30000 means a hang
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        addr_pins = 3'h5;
        seed = 32'h0001_4924;
        num_errors = 0;
        tests_run = 0;
        exp_sh = lod_pkg::DATA_RST;
        exp_out = lod_pkg::OUT_RST;
        dir_sub = '{8'h11, 8'h22, 8'h44, 8'h33, 8'h00, 8'hff};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(shift_q, lod_pkg::DATA_RST, "reset shift");
        check(out_on, lod_pkg::OUT_RST, "reset outputs");
        // Every command in both directions, then undefined codes
        for (int i = 0; i < 6; i++) begin
            for (int r = 0; r < 2; r++) begin
                txn(4'hc, 3'h5, r[0], dir_sub[i], 8'ha5 ^ 8'(i * 37));
            end
        end
        txn(4'hd, 3'h5, 1'b0, 8'h44, 8'h3c);
        txn(4'hc, 3'h4, 1'b0, 8'h44, 8'h3c);
        // Random mix, mostly well addressed so commands take effect
        for (int n = 0; n < 40; n++) begin
            seed = xs(seed);
            rnd = xs(seed);
            addr_pins <= seed[2:0];
            @(posedge clk);
            txn(seed[31:29] == 3'h0 ? seed[7:4] : lod_pkg::GROUP_ID,
                seed[28:27] == 2'h0 ? seed[10:8] : seed[2:0], seed[11],
                seed[23:22] == 2'h3 ? seed[19:12] : dir_sub[seed[23:22]], rnd[15:8]);
        end
        end_sim();
    end
endmodule
`default_nettype wire
